// *** inc/hbk_pkg.sv ***
`default_nettype none
package hbk_pkg;
  // ==========================================================
  // holding word numbers
  localparam logic [15:0] HW_SLAVE_ADDR = 16'h0001;
  localparam logic [15:0] HW_BAUD       = 16'h0002;
  localparam logic [15:0] HW_PARITY     = 16'h0003;
  localparam logic [15:0] HW_DEV_TYPE   = 16'h0004;
  localparam logic [15:0] HW_HW_REV     = 16'h0005;
  localparam logic [15:0] HW_FW_REV     = 16'h0006;
  localparam logic [15:0] HW_RESERVED   = 16'h0007;
  localparam logic [15:0] HW_TIMEOUT    = 16'h0008;
  localparam logic [15:0] HW_TERM       = 16'h0009;
  localparam logic [15:0] HW_RESTORE    = 16'h000a;
  localparam logic [15:0] HW_MIN_ALERT  = 16'h000b;

  // ==========================================================
  // field widths, limits and factory values
  localparam int          ADDR_W        = 8;
  localparam int          BAUD_W        = 3;
  localparam int          PAR_W         = 2;
  localparam int          TMO_W         = 6;
  localparam logic [7:0]  SLAVE_MIN     = 8'h01;
  localparam logic [7:0]  SLAVE_MAX     = 8'hf7;
  localparam logic [7:0]  SLAVE_RST     = 8'h01;
  localparam logic [2:0]  BAUD_MAX      = 3'h6;
  localparam logic [2:0]  BAUD_RST      = 3'h2;
  localparam logic [1:0]  PAR_NONE      = 2'h0;
  localparam logic [1:0]  PAR_EVEN      = 2'h1;
  localparam logic [1:0]  PAR_ODD       = 2'h2;
  localparam logic [1:0]  PAR_RST       = PAR_EVEN;
  localparam logic [5:0]  TMO_MAX       = 6'h3c;
  localparam logic [5:0]  TMO_RST       = 6'h00;
  localparam logic        TERM_RST      = 1'b0;
  localparam logic        RESTORE_RST   = 1'b0;
  localparam logic [15:0] MIN_ALERT_RST = 16'h0000;
  localparam logic [16:0] ALERT_MARGIN  = 17'h00032;

  // ==========================================================
  // exception codes of the answer
  localparam logic [7:0]  EXC_NONE      = 8'h00;
  localparam logic [7:0]  EXC_BAD_ADDR  = 8'h02;
  localparam logic [7:0]  EXC_BAD_VALUE = 8'h03;

  // ==========================================================
  // timing
  localparam longint      CLK_HZ        = 25_000_000;
  localparam longint      MINUTE_S      = 60;
  localparam logic [31:0] CYC_PER_MIN   = 32'(MINUTE_S * CLK_HZ);

  typedef enum logic {HBK_IDLE, HBK_RESTORE} hbk_state_t;
endpackage : hbk_pkg
`default_nettype wire

// *** inc/hbk_tmo_if.sv ***
`default_nettype none
// ==========================================================
// link between bank and communication-loss timer
interface hbk_tmo_if;
  logic       activity;
  logic [5:0] limit_min;
  logic       expired;
  modport bank  (output activity, output limit_min, input expired);
  modport timer (input activity, input limit_min, output expired);
endinterface : hbk_tmo_if
`default_nettype wire

// *** hdl/hbk_comm_timer.sv ***
`default_nettype none
module hbk_comm_timer
  import hbk_pkg::*;
#(
  parameter logic [31:0] MIN_CYCLES = CYC_PER_MIN
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  hbk_tmo_if.timer   tmo
);
  logic [31:0] pre_reg,  pre_next;
  logic [5:0]  min_reg,  min_next;
  logic        exp_reg,  exp_next;

  // ==========================================================
  // minute prescaler and idle-minute count
  always_comb begin
    pre_next = pre_reg;
    min_next = min_reg;
    exp_next = exp_reg;
    if (tmo.activity || tmo.limit_min == TMO_RST) begin
      // traffic to this unit (activity), or timeout off, restarts the wait
      pre_next = 32'h0;
      min_next = 6'h0;
      exp_next = 1'b0;
    end else if (!exp_reg) begin
      if (pre_reg == MIN_CYCLES - 32'h1) begin
        pre_next = 32'h0;
        min_next = min_reg + 6'h1;
      end else begin
        pre_next = pre_reg + 32'h1;
      end
      exp_next = (min_reg >= tmo.limit_min);  // see RULE_07
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 32'h0;
      min_reg <= 6'h0;
      exp_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      min_reg <= min_next;
      exp_reg <= exp_next;
    end
  end

  assign tmo.expired = exp_reg;
endmodule : hbk_comm_timer
`default_nettype wire

// *** hdl/hbk_holding_bank.sv ***
`default_nettype none
// Notes on behaviour
// RULE_01 - the bank answers only requests whose unit number equals the slave address, 1 to 247, default 1.
// RULE_02 - the bit-rate code takes 0 to 6 for 4800 up to 230400 baud and resets to 2.
// RULE_03 - the parity code selects 8N1 (0), 8E1 (1) or 8O1 (2), with even parity as default.
// RULE_04 - the device type word is a fixed code and writes to it change nothing.
// RULE_05 - the hardware revision word holds major in the high byte, minor in the low, read only.
// RULE_06 - the firmware revision word uses the same byte format and is read only.
// RULE_07 - with a nonzero timeout of 1 to 60 minutes and no traffic that long, all outputs go to zero; the code only raises OUTPUTS_OFF.
// RULE_08 - the termination word connects the line termination at 1, disconnects at 0, default 0.
// RULE_09 - writing 1 to the restore word brings every holding register back to its factory value.
// RULE_10 - after the restore the restore word clears itself to 0, which reads as idle.
// RULE_11 - the minimum pressure alert refuses values above the setpoint or above range less 50 Pa.
module hbk_holding_bank
  import hbk_pkg::*;
#(
  parameter logic [31:0] MIN_CYCLES = CYC_PER_MIN,
  parameter logic [15:0] DEV_TYPE   = 16'h0abc,  // arbitrary value
  parameter logic [15:0] HW_REV     = 16'h0102,  // arbitrary value
  parameter logic [15:0] FW_REV     = 16'h0304   // arbitrary value
) (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_WRITE,
  input  wire logic [7:0]  REQ_UNIT,
  input  wire logic [15:0] REQ_ADDR,
  input  wire logic [15:0] REQ_WDATA,
  input  wire logic [15:0] SETPOINT_PA,
  input  wire logic [15:0] RANGE_MAX_PA,
  output logic             RSP_VALID,
  output logic [15:0]      RSP_RDATA,
  output logic [7:0]       RSP_EXC,
  output logic [7:0]       SLAVE_ADDR,
  output logic [2:0]       BAUD_CODE,
  output logic [1:0]       PARITY_CODE,
  output logic             LINE_TERMINATION_SWITCH,
  output logic [15:0]      MIN_ALERT_PA,
  output logic             OUTPUTS_OFF
);
  // ==========================================================
  // state
  hbk_state_t          st_reg,      st_next;
  logic [ADDR_W-1:0]   slave_reg,   slave_next;
  logic [BAUD_W-1:0]   baud_reg,    baud_next;
  logic [PAR_W-1:0]    parity_reg,  parity_next;
  logic [TMO_W-1:0]    tmo_reg,     tmo_next;
  logic                term_reg,    term_next;
  logic                restore_reg, restore_next;
  logic [15:0]         alert_reg,   alert_next;
  logic                rvalid_reg,  rvalid_next;
  logic [15:0]         rdata_reg,   rdata_next;
  logic [7:0]          exc_reg,     exc_next;

  // two-stage synchronisers for the levels that come from outside the clock
  logic [15:0]         setp_meta_reg,  setp_sync_reg;
  logic [15:0]         range_meta_reg, range_sync_reg;

  logic                hit;
  logic                wr;
  logic [16:0]         alert_ceiling;
  logic [15:0]         read_word;
  logic                value_ok;
  logic                addr_ok;

  hbk_tmo_if tmo ();

  // ==========================================================
  // pin-level limits pass two flops; only the second stage is read
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      setp_meta_reg  <= 16'h0;
      setp_sync_reg  <= 16'h0;
      range_meta_reg <= 16'h0;
      range_sync_reg <= 16'h0;
    end else begin
      setp_meta_reg  <= SETPOINT_PA;
      setp_sync_reg  <= setp_meta_reg;
      range_meta_reg <= RANGE_MAX_PA;
      range_sync_reg <= range_meta_reg;
    end
  end

  // ==========================================================
  // request decode
  assign hit = REQ_VALID && (REQ_UNIT == slave_reg);  // see RULE_01
  assign wr  = hit && REQ_WRITE;
  assign addr_ok = (REQ_ADDR >= HW_SLAVE_ADDR) && (REQ_ADDR <= HW_MIN_ALERT);
  // range less margin; a tiny range leaves only zero legal
  assign alert_ceiling = ({1'b0, range_sync_reg} >= ALERT_MARGIN) ?
                         ({1'b0, range_sync_reg} - ALERT_MARGIN) : 17'h0;

  // ==========================================================
  // read multiplexer, narrow fields zero-extended
  always_comb begin
    read_word = 16'h0;
    case (REQ_ADDR)
      HW_SLAVE_ADDR: read_word = {8'h0, slave_reg};
      HW_BAUD:       read_word = {13'h0, baud_reg};
      HW_PARITY:     read_word = {14'h0, parity_reg};
      HW_DEV_TYPE:   read_word = DEV_TYPE;               // see RULE_04
      HW_HW_REV:     read_word = HW_REV;                 // see RULE_05
      HW_FW_REV:     read_word = FW_REV;                 // see RULE_06
      HW_RESERVED:   read_word = 16'h0;
      HW_TIMEOUT:    read_word = {10'h0, tmo_reg};
      HW_TERM:       read_word = {15'h0, term_reg};
      HW_RESTORE:    read_word = {15'h0, restore_reg};   // see RULE_10
      HW_MIN_ALERT:  read_word = alert_reg;
      default:       read_word = 16'h0;
    endcase
  end

  // ==========================================================
  // write range checks; a refused value keeps the old one
  always_comb begin
    value_ok = 1'b1;
    case (REQ_ADDR)
      HW_SLAVE_ADDR: value_ok = (REQ_WDATA >= {8'h0, SLAVE_MIN}) &&
                                (REQ_WDATA <= {8'h0, SLAVE_MAX});  // see RULE_01
      HW_BAUD:       value_ok = (REQ_WDATA <= {13'h0, BAUD_MAX}); // see RULE_02
      HW_PARITY:     value_ok = (REQ_WDATA <= {14'h0, PAR_ODD});  // see RULE_03
      HW_TIMEOUT:    value_ok = (REQ_WDATA <= {10'h0, TMO_MAX});  // see RULE_07
      HW_TERM:       value_ok = (REQ_WDATA <= 16'h0001);          // see RULE_08
      HW_RESTORE:    value_ok = (REQ_WDATA <= 16'h0001);          // see RULE_09
      HW_MIN_ALERT:  value_ok = (REQ_WDATA <= setp_sync_reg) &&
                                ({1'b0, REQ_WDATA} <= alert_ceiling); // see RULE_11
      default:       value_ok = 1'b1;  // read-only and reserved words accept and ignore
    endcase
  end

  // ==========================================================
  // next values of the holding words and the answer
  always_comb begin
    st_next      = st_reg;
    slave_next   = slave_reg;
    baud_next    = baud_reg;
    parity_next  = parity_reg;
    tmo_next     = tmo_reg;
    term_next    = term_reg;
    restore_next = restore_reg;
    alert_next   = alert_reg;
    rvalid_next  = 1'b0;
    rdata_next   = rdata_reg;
    exc_next     = EXC_NONE;

    // restore runs one cycle after the command word is written
    case (st_reg)
      HBK_IDLE: begin
        st_next = HBK_IDLE;
      end
      HBK_RESTORE: begin
        slave_next   = SLAVE_RST;      // see RULE_09
        baud_next    = BAUD_RST;
        parity_next  = PAR_RST;
        tmo_next     = TMO_RST;
        term_next    = TERM_RST;
        alert_next   = MIN_ALERT_RST;
        restore_next = RESTORE_RST;    // see RULE_10
        st_next      = HBK_IDLE;
      end
      default: begin
        st_next = HBK_IDLE;
      end
    endcase

    // a request in the restore cycle lands on top of the defaults
    if (hit) begin
      rvalid_next = 1'b1;
      if (!addr_ok) begin
        exc_next   = EXC_BAD_ADDR;
        rdata_next = 16'h0;
      end else if (wr) begin
        rdata_next = REQ_WDATA;
        if (!value_ok) begin
          exc_next = EXC_BAD_VALUE;
        end else begin
          case (REQ_ADDR)
            HW_SLAVE_ADDR: slave_next  = REQ_WDATA[ADDR_W-1:0];
            HW_BAUD:       baud_next   = REQ_WDATA[BAUD_W-1:0];
            HW_PARITY:     parity_next = REQ_WDATA[PAR_W-1:0];
            HW_TIMEOUT:    tmo_next    = REQ_WDATA[TMO_W-1:0];
            HW_TERM:       term_next   = REQ_WDATA[0];          // see RULE_08
            HW_MIN_ALERT:  alert_next  = REQ_WDATA;             // see RULE_11
            HW_RESTORE: begin
              restore_next = REQ_WDATA[0];
              if (REQ_WDATA[0]) begin
                st_next = HBK_RESTORE;                          // see RULE_09
              end
            end
            default: begin
              rdata_next = REQ_WDATA;  // read-only words stay unchanged
            end
          endcase
        end
      end else begin
        rdata_next = read_word;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg      <= HBK_IDLE;
      slave_reg   <= SLAVE_RST;
      baud_reg    <= BAUD_RST;
      parity_reg  <= PAR_RST;
      tmo_reg     <= TMO_RST;
      term_reg    <= TERM_RST;
      restore_reg <= RESTORE_RST;
      alert_reg   <= MIN_ALERT_RST;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 16'h0;
      exc_reg     <= EXC_NONE;
    end else begin
      st_reg      <= st_next;
      slave_reg   <= slave_next;
      baud_reg    <= baud_next;
      parity_reg  <= parity_next;
      tmo_reg     <= tmo_next;
      term_reg    <= term_next;
      restore_reg <= restore_next;
      alert_reg   <= alert_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      exc_reg     <= exc_next;
    end
  end

  // ==========================================================
  // communication-loss watch; only traffic to this unit counts
  assign tmo.activity  = hit;
  assign tmo.limit_min = tmo_reg;

  hbk_comm_timer #(
    .MIN_CYCLES (MIN_CYCLES)
  ) u_timer (
    .clk   (MCLK),
    .rst_n (RESETN),
    .tmo   (tmo.timer)
  );

  // ==========================================================
  // outputs, all from flip-flops
  assign RSP_VALID               = rvalid_reg;
  assign RSP_RDATA               = rdata_reg;
  assign RSP_EXC                 = exc_reg;
  assign SLAVE_ADDR              = slave_reg;
  assign BAUD_CODE               = baud_reg;
  assign PARITY_CODE             = parity_reg;
  assign LINE_TERMINATION_SWITCH = term_reg;
  assign MIN_ALERT_PA            = alert_reg;
  assign OUTPUTS_OFF             = tmo.expired;  // see RULE_07
endmodule : hbk_holding_bank
`default_nettype wire

// *** tb/hbk_bank_chk.sv ***
`default_nettype none
module hbk_bank_chk
  import hbk_pkg::*;
#(
  parameter logic [31:0] MIN_CYCLES = CYC_PER_MIN
) (
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic        REQ_VALID,
  input wire logic        REQ_WRITE,
  input wire logic [7:0]  REQ_UNIT,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  input wire logic [15:0] SETPOINT_PA,
  input wire logic        RSP_VALID,
  input wire logic [7:0]  RSP_EXC,
  input wire logic [7:0]  SLAVE_ADDR,
  input wire logic [2:0]  BAUD_CODE,
  input wire logic [1:0]  PARITY_CODE,
  input wire logic        LINE_TERMINATION_SWITCH,
  input wire logic [15:0] MIN_ALERT_PA,
  input wire logic        OUTPUTS_OFF
);
  logic        tk;
  logic        wr;
  logic [31:0] idle_reg;
  logic [31:0] idle_next;
  // =========================================
  // idle counter, saturating so a long quiet run never wraps
  assign tk = REQ_VALID && (REQ_UNIT == SLAVE_ADDR);
  assign wr = tk && REQ_WRITE;
  always_comb begin
    idle_next = tk ? 32'h0 : idle_reg + ((&idle_reg) ? 32'h0 : 32'h1);
  end
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) idle_reg <= 32'h0;
    else idle_reg <= idle_next;
  end
  // =========================================
  // properties
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  a_ans_taken: assert property (tk |=> RSP_VALID)
    else $error("answer missing");
  a_no_stray: assert property (!tk |=> !RSP_VALID)
    else $error("stray answer");
  a_slave_range: assert property (SLAVE_ADDR >= SLAVE_MIN && SLAVE_ADDR <= SLAVE_MAX)
    else $error("slave address out of range");
  a_baud_range: assert property (BAUD_CODE <= BAUD_MAX)
    else $error("bit-rate code out of range");
  a_parity_range: assert property (PARITY_CODE <= PAR_ODD)
    else $error("parity code out of range");
  a_ro_accept: assert property (wr && REQ_ADDR inside {[HW_DEV_TYPE:HW_FW_REV]}
    |=> RSP_EXC == EXC_NONE) else $error("read-only write refused");
  a_term_follow: assert property (wr && REQ_ADDR == HW_TERM && REQ_WDATA <= 16'h0001
    |=> LINE_TERMINATION_SWITCH == $past(REQ_WDATA[0])) else $error("termination wrong");
  a_alert_refuse: assert property (wr && REQ_ADDR == HW_MIN_ALERT && REQ_WDATA > SETPOINT_PA
    |=> RSP_EXC == EXC_BAD_VALUE) else $error("alert above setpoint taken");
  a_restore_dflt: assert property ((wr && REQ_ADDR == HW_RESTORE && REQ_WDATA == 16'h0001)
    ##1 !REQ_VALID |=> SLAVE_ADDR == SLAVE_RST && BAUD_CODE == BAUD_RST
    && PARITY_CODE == PAR_RST && LINE_TERMINATION_SWITCH == TERM_RST
    && MIN_ALERT_PA == MIN_ALERT_RST) else $error("restore left a word");
  a_off_late: assert property ($rose(OUTPUTS_OFF) |-> idle_reg >= MIN_CYCLES)
    else $error("outputs off too early");
  a_off_clear: assert property (OUTPUTS_OFF && tk |-> ##[1:2] !OUTPUTS_OFF)
    else $error("outputs off not cleared");
endmodule : hbk_bank_chk

bind hbk_holding_bank hbk_bank_chk #(.MIN_CYCLES(MIN_CYCLES)) hbk_bank_chk_inst (
  .MCLK(MCLK), .RESETN(RESETN), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
  .REQ_UNIT(REQ_UNIT), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
  .SETPOINT_PA(SETPOINT_PA), .RSP_VALID(RSP_VALID), .RSP_EXC(RSP_EXC),
  .SLAVE_ADDR(SLAVE_ADDR), .BAUD_CODE(BAUD_CODE), .PARITY_CODE(PARITY_CODE),
  .LINE_TERMINATION_SWITCH(LINE_TERMINATION_SWITCH), .MIN_ALERT_PA(MIN_ALERT_PA),
  .OUTPUTS_OFF(OUTPUTS_OFF));
`default_nettype wire

// *** tb/hbk_master.sv ***
`default_nettype none
module hbk_master (
  input  wire logic        MCLK,
  output var  logic        REQ_VALID,
  output var  logic        REQ_WRITE,
  output var  logic [7:0]  REQ_UNIT,
  output var  logic [15:0] REQ_ADDR,
  output var  logic [15:0] REQ_WDATA,
  input  wire logic        RSP_VALID,
  input  wire logic [15:0] RSP_RDATA,
  input  wire logic [7:0]  RSP_EXC
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    REQ_VALID = 1'b0;
    REQ_WRITE = 1'b0;
    REQ_UNIT  = 8'h00;
    REQ_ADDR  = 16'h0000;
    REQ_WDATA = 16'h0000;
  end
  // =========================================
  // one-cycle request; idle lines flip so no stale value passes
  task automatic xfer(input logic w, input logic [7:0] u, input logic [15:0] a,
                      input logic [15:0] d, output logic ok, output logic [15:0] rd,
                      output logic [7:0] ex);
    @(posedge MCLK);
    #1;
    REQ_VALID = 1'b1;
    REQ_WRITE = w;
    REQ_UNIT  = u;
    REQ_ADDR  = a;
    REQ_WDATA = d;
    @(posedge MCLK);
    #1;
    REQ_VALID = 1'b0;
    REQ_WRITE = ~w;
    REQ_UNIT  = ~u;
    REQ_ADDR  = ~a;
    REQ_WDATA = ~d;
    ok = RSP_VALID;
    rd = RSP_RDATA;
    ex = RSP_EXC;
  endtask : xfer
endmodule : hbk_master
`default_nettype wire

// *** tb/modbus_holding_config_bank_bench.sv ***
`default_nettype none
module modbus_holding_config_bank_bench;
  import hbk_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MIN_CYC = 32'h0000000a;
  localparam logic [15:0] DEV_T   = 16'h0abc;  // arbitrary value
  localparam logic [15:0] HW_R    = 16'h0102;  // arbitrary value
  localparam logic [15:0] FW_R    = 16'h0304;  // arbitrary value
  localparam logic [15:0] DFLT [1:11] = '{16'h1, 16'h2, 16'h1, DEV_T, HW_R, FW_R,
                                          16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic        MCLK, RESETN, v, w, rv, off, term, ok;
  logic [7:0]  u, ex, sa, unit, x;
  logic [15:0] a, d, rd, setp, rng, alert, r;
  logic [2:0]  baud;
  logic [1:0]  par;
  int          errors, total_checks, n;
  hbk_master hbk_master_inst (.MCLK(MCLK), .REQ_VALID(v), .REQ_WRITE(w), .REQ_UNIT(u),
    .REQ_ADDR(a), .REQ_WDATA(d), .RSP_VALID(rv), .RSP_RDATA(rd), .RSP_EXC(ex));
  hbk_holding_bank #(.MIN_CYCLES(MIN_CYC), .DEV_TYPE(DEV_T), .HW_REV(HW_R), .FW_REV(FW_R))
    hbk_holding_bank_inst (.MCLK(MCLK), .RESETN(RESETN), .REQ_VALID(v), .REQ_WRITE(w),
    .REQ_UNIT(u), .REQ_ADDR(a), .REQ_WDATA(d), .SETPOINT_PA(setp), .RANGE_MAX_PA(rng),
    .RSP_VALID(rv), .RSP_RDATA(rd), .RSP_EXC(ex), .SLAVE_ADDR(sa), .BAUD_CODE(baud),
    .PARITY_CODE(par), .LINE_TERMINATION_SWITCH(term), .MIN_ALERT_PA(alert),
    .OUTPUTS_OFF(off));
  // =========================================
  // compare, access and closing helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [15:0] ad, input logic [15:0] wd,
                     input logic [7:0] ee, input logic [15:0] ed);
    hbk_master_inst.xfer(wr, unit, ad, wd, ok, r, x);
    chk("answer", 16'h0001, 16'(ok));
    chk("exception", 16'(ee), 16'(x));
    if (ee !== EXC_BAD_VALUE) chk("data", ed, r);
  endtask : acc
  task automatic dflt();
    for (int i = 1; i <= 11; i++) acc(1'b0, 16'(i), 16'h0, EXC_NONE, DFLT[i]);
    chk("outputs", 16'h1210, {sa[3:0], 1'b0, baud, 2'b0, par, term, alert[2:0]});
  endtask : dflt
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  // =========================================
  // main sequence
  initial begin
    RESETN = 1'b0;
    setp = 16'h01f4;
    rng = 16'h03e8;
    unit = 8'h01;
    repeat (16) @(posedge MCLK);
    #1 RESETN = 1'b1;
    dflt();
    acc(1'b0, 16'h0000, 16'h0, EXC_BAD_ADDR, 16'h0);
    acc(1'b0, 16'h000c, 16'h0, EXC_BAD_ADDR, 16'h0);
    for (int i = 0; i <= 7; i++) begin
      acc(1'b1, HW_BAUD, 16'(i), (i == 7) ? EXC_BAD_VALUE : EXC_NONE, 16'(i));
      chk("baud", (i == 7) ? 16'h6 : 16'(i), 16'(baud));
    end
    for (int i = 0; i <= 3; i++) begin
      acc(1'b1, HW_PARITY, 16'(i), (i == 3) ? EXC_BAD_VALUE : EXC_NONE, 16'(i));
      chk("parity", (i == 3) ? 16'h2 : 16'(i), 16'(par));
    end
    for (int i = 0; i <= 2; i++) begin
      acc(1'b1, HW_TERM, 16'(i), (i == 2) ? EXC_BAD_VALUE : EXC_NONE, 16'(i));
      chk("termination", (i == 2) ? 16'h1 : 16'(i), 16'(term));
    end
    for (int i = 4; i <= 6; i++) begin
      acc(1'b1, 16'(i), 16'h5a5a, EXC_NONE, 16'h5a5a);
      acc(1'b0, 16'(i), 16'h0, EXC_NONE, DFLT[i]);
    end
    acc(1'b1, HW_MIN_ALERT, 16'h01f5, EXC_BAD_VALUE, 16'h0);
    acc(1'b1, HW_MIN_ALERT, 16'h01f4, EXC_NONE, 16'h01f4);
    setp = 16'h03e8;
    // the setpoint crosses two synchroniser flops before the bank sees it
    repeat (2) @(posedge MCLK);
    #1;
    acc(1'b1, HW_MIN_ALERT, 16'h03b7, EXC_BAD_VALUE, 16'h0);
    acc(1'b1, HW_MIN_ALERT, 16'h03b6, EXC_NONE, 16'h03b6);
    chk("alert", 16'h03b6, alert);
    acc(1'b1, HW_SLAVE_ADDR, 16'h0000, EXC_BAD_VALUE, 16'h0);
    acc(1'b1, HW_SLAVE_ADDR, 16'h00f8, EXC_BAD_VALUE, 16'h0);
    acc(1'b1, HW_SLAVE_ADDR, 16'h00f7, EXC_NONE, 16'h00f7);
    hbk_master_inst.xfer(1'b0, 8'h01, HW_BAUD, 16'h0, ok, r, x);
    chk("old unit ignored", 16'h0, 16'(ok));
    unit = 8'hf7;
    acc(1'b1, HW_TIMEOUT, 16'h003d, EXC_BAD_VALUE, 16'h0);
    acc(1'b1, HW_TIMEOUT, 16'h003c, EXC_NONE, 16'h003c);
    acc(1'b1, HW_TIMEOUT, 16'h0001, EXC_NONE, 16'h0001);
    n = 0;
    while (off !== 1'b1 && n < 40) begin
      @(posedge MCLK);
      #1 n++;
    end
    chk("off delay", 16'h1, 16'(n >= MIN_CYC && n <= MIN_CYC + 5));
    if (n >= 40) results();
    acc(1'b0, HW_TIMEOUT, 16'h0, EXC_NONE, 16'h0001);
    @(posedge MCLK);
    #1 chk("off cleared", 16'h0, 16'(off));
    acc(1'b1, HW_RESTORE, 16'h0001, EXC_NONE, 16'h0001);
    unit = 8'h01;
    dflt();
    repeat (30) @(posedge MCLK);
    chk("timeout restored", 16'h0, 16'(off));
    results();
  end
endmodule : modbus_holding_config_bank_bench
`default_nettype wire
